// ==== hw/csi_pkg.sv ====
/*
 * Package for the comparator status and interrupt register bank: register
 * offsets, field positions, reset values and the bus carrier structs.
 * Assumes a classic Wishbone slave with 32-bit data and byte addressing.
 */
package csi_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_STAT     = 8'h00;
    localparam logic [7:0] OFF_STAT_CLR = 8'h04;
    localparam logic [7:0] OFF_STAT_SET = 8'h08;
    localparam logic [7:0] OFF_STAT_INV = 8'h0C;
    localparam logic [7:0] OFF_IFLAG    = 8'h10;
    localparam logic [7:0] OFF_IEN      = 8'h14;
    localparam logic [7:0] OFF_IPRIO    = 8'h18;
    localparam logic [7:0] OFF_EVCFG    = 8'h1C;

    // status register fields
    localparam int          STAT_C1OUT = 0;
    localparam int          STAT_C2OUT = 1;
    localparam int          STAT_SIDL  = 13;
    localparam int          STAT_FRZ   = 14;
    localparam logic [31:0] STAT_WMASK = 32'h0000_6000;
    localparam logic [1:0]  STAT_RST   = 2'h0;

    // interrupt flag / enable fields
    localparam int          IRQ_CMP1 = 3;
    localparam int          IRQ_CMP2 = 4;
    localparam logic [1:0]  IRQ_RST  = 2'h0;

    // priority fields
    localparam int          PRI1_LSB = 10;
    localparam int          SUB1_LSB = 8;
    localparam int          PRI2_LSB = 18;
    localparam int          SUB2_LSB = 16;
    localparam logic [2:0]  PRI_RST  = 3'h0;
    localparam logic [1:0]  SUB_RST  = 2'h0;
    localparam logic [2:0]  PRI_OFF  = 3'h0;

    // event selection per comparator: 2 bits, comparator 1 at 1:0, 2 at 3:2
    localparam logic [1:0]  EV_NONE  = 2'h0;
    localparam logic [1:0]  EV_RISE  = 2'h1;
    localparam logic [1:0]  EV_FALL  = 2'h2;
    localparam logic [1:0]  EV_ANY   = 2'h3;
    localparam logic [3:0]  EVCFG_RST = 4'hF;

    localparam logic [31:0] RD_UNDEF = 32'h0000_0000;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } csi_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } csi_wb_rsp_t;

    typedef struct packed {
        logic [2:0] pri;
        logic [1:0] sub;
    } csi_prio_t;
endpackage

// ==== hw/csi_regs.sv ====
/*
 * Comparator status alias ports, interrupt flags, enables and priority
 * fields for two comparators, as a classic Wishbone slave.
 * Assumes synchronous comparator outputs and a single 20 MHz clock.
 */
// Implementation choices: register access over Wishbone and the placing of the registers.
module csi_regs (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire csi_pkg::csi_wb_req_t wb_req_i,
    output csi_pkg::csi_wb_rsp_t      wb_rsp_o,
    input  wire logic [1:0]           cmp_out_i,
    output logic                      irq_o,
    output csi_pkg::csi_prio_t        cmp1_prio_o,
    output csi_pkg::csi_prio_t        cmp2_prio_o
);
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic [1:0]  stat_q;       // bit 0 sidl, bit 1 frz
    logic [1:0]  stat_d;
    logic [1:0]  flag_q;
    logic [1:0]  flag_d;
    logic [1:0]  en_q;
    logic [1:0]  out_q;
    logic [3:0]  evcfg_q;
    logic [2:0]  pri1_q;
    logic [1:0]  sub1_q;
    logic [2:0]  pri2_q;
    logic [1:0]  sub2_q;
    logic [1:0]  event_w;
    logic [31:0] stat_rd_w;

    // bus decode; single-cycle ack, dropped the cycle after
    wire        req_w   = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
    wire        wr_w    = req_w & wb_req_i.we;
    wire [31:0] wmask_w = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                           {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
    wire [31:0] wd_w    = wb_req_i.dat & wmask_w;
    wire        wr_stat = wr_w & (wb_req_i.adr == csi_pkg::OFF_STAT);
    wire        wr_clr  = wr_w & (wb_req_i.adr == csi_pkg::OFF_STAT_CLR);
    wire        wr_set  = wr_w & (wb_req_i.adr == csi_pkg::OFF_STAT_SET);
    wire        wr_inv  = wr_w & (wb_req_i.adr == csi_pkg::OFF_STAT_INV);
    wire        wr_flag = wr_w & (wb_req_i.adr == csi_pkg::OFF_IFLAG);
    wire        wr_en   = wr_w & (wb_req_i.adr == csi_pkg::OFF_IEN);
    wire        wr_pri  = wr_w & (wb_req_i.adr == csi_pkg::OFF_IPRIO);
    wire        wr_ev   = wr_w & (wb_req_i.adr == csi_pkg::OFF_EVCFG);

    // only sidl and frz are writable; outputs sit outside the mask
    wire [31:0] ad_w  = wd_w & csi_pkg::STAT_WMASK;
    wire [1:0]  ad2_w = {ad_w[csi_pkg::STAT_FRZ], ad_w[csi_pkg::STAT_SIDL]};
    wire [1:0]  pw_w  = {wd_w[csi_pkg::STAT_FRZ], wd_w[csi_pkg::STAT_SIDL]};

    // status next value; zero bits of the alias word pass through
    always_comb begin
        stat_d = stat_q;
        if (wr_stat) begin
            stat_d = pw_w;
        end else if (wr_clr) begin
            stat_d = stat_q & ~ad2_w;
        end else if (wr_set) begin
            stat_d = stat_q | ad2_w;
        end else if (wr_inv) begin
            stat_d = stat_q ^ ad2_w;
        end
    end

    // event detect per comparator from the sampled output
    generate
        for (genvar i = 0; i < 2; i++) begin : g_ev
            wire [1:0] sel_w  = evcfg_q[2*i +: 2];
            wire       rise_w = cmp_out_i[i] & ~out_q[i];
            wire       fall_w = ~cmp_out_i[i] & out_q[i];
            assign event_w[i] = ((sel_w == csi_pkg::EV_RISE) & rise_w)
                              | ((sel_w == csi_pkg::EV_FALL) & fall_w)
                              | ((sel_w == csi_pkg::EV_ANY) & (rise_w | fall_w));
        end
    endgenerate

    // flags: write value, then events win over a same-cycle clear
    wire [1:0] fw_w = {wd_w[csi_pkg::IRQ_CMP2], wd_w[csi_pkg::IRQ_CMP1]};
    always_comb begin
        flag_d = wr_flag ? fw_w : flag_q;
        flag_d = flag_d | event_w;
    end

    // read mux; alias ports read as zero
    assign stat_rd_w = {17'h00000, stat_q[1], stat_q[0], 11'h000, out_q[1], out_q[0]};
    always_comb begin
        rdat_d = 32'h0000_0000;
        case (wb_req_i.adr)
            csi_pkg::OFF_STAT:     rdat_d = stat_rd_w;
            csi_pkg::OFF_STAT_CLR: rdat_d = csi_pkg::RD_UNDEF;
            csi_pkg::OFF_STAT_SET: rdat_d = csi_pkg::RD_UNDEF;
            csi_pkg::OFF_STAT_INV: rdat_d = csi_pkg::RD_UNDEF;
            csi_pkg::OFF_IFLAG:    rdat_d = {27'h0, flag_q, 3'h0};
            csi_pkg::OFF_IEN:      rdat_d = {27'h0, en_q, 3'h0};
            csi_pkg::OFF_IPRIO:    rdat_d = {11'h0, pri2_q, sub2_q, 3'h0,
                                             pri1_q, sub1_q, 8'h00};
            csi_pkg::OFF_EVCFG:    rdat_d = {28'h0, evcfg_q};
            default:               rdat_d = 32'h0000_0000;
        endcase
    end

    // bus answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= req_w;
            rdat_q <= rdat_d;
        end
    end

    // status and sampled outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= csi_pkg::STAT_RST;
            out_q  <= 2'h0;
        end else begin
            stat_q <= stat_d;
            out_q  <= cmp_out_i;
        end
    end

    // flags and enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= csi_pkg::IRQ_RST;
            en_q   <= csi_pkg::IRQ_RST;
        end else begin
            flag_q <= flag_d;
            if (wr_en) en_q <= {wd_w[csi_pkg::IRQ_CMP2], wd_w[csi_pkg::IRQ_CMP1]};
        end
    end

    // priorities and event selection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pri1_q  <= csi_pkg::PRI_RST;
            sub1_q  <= csi_pkg::SUB_RST;
            pri2_q  <= csi_pkg::PRI_RST;
            sub2_q  <= csi_pkg::SUB_RST;
            evcfg_q <= csi_pkg::EVCFG_RST;
        end else begin
            if (wr_pri) begin
                pri1_q <= wd_w[csi_pkg::PRI1_LSB +: 3];
                sub1_q <= wd_w[csi_pkg::SUB1_LSB +: 2];
                pri2_q <= wd_w[csi_pkg::PRI2_LSB +: 3];
                sub2_q <= wd_w[csi_pkg::SUB2_LSB +: 2];
            end
            if (wr_ev) evcfg_q <= wd_w[3:0];
        end
    end

    // forwarding: flag, enable and nonzero priority all needed
    wire pass1_w = flag_q[0] & en_q[0] & (pri1_q != csi_pkg::PRI_OFF);
    wire pass2_w = flag_q[1] & en_q[1] & (pri2_q != csi_pkg::PRI_OFF);
    assign irq_o = pass1_w | pass2_w;

    assign wb_rsp_o.ack = ack_q;
    assign wb_rsp_o.dat = rdat_q;
    assign cmp1_prio_o  = '{pri: pri1_q, sub: sub1_q};
    assign cmp2_prio_o  = '{pri: pri2_q, sub: sub2_q};

    // clear alias empties every written writable bit
    AST_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_clr && !wr_stat
        |=> (stat_q & $past(ad2_w)) == 2'h0)
        else $error("clear alias left a bit set");

    // set alias fills every written writable bit
    AST_SET: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_set
        |=> ((stat_q & $past(ad2_w)) == $past(ad2_w)))
        else $error("set alias missed a bit");

    // invert alias flips exactly the written bits
    AST_INV: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_inv
        |=> stat_q == ($past(stat_q) ^ $past(ad2_w)))
        else $error("invert alias wrong");

    // no status write, no status change
    AST_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_stat && !wr_clr && !wr_set && !wr_inv
        |=> $stable(stat_q))
        else $error("status changed without a write");

    // zero bits of a clear word keep their value
    AST_CLR_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_clr
        |=> (stat_q & ~$past(ad2_w)) == ($past(stat_q) & ~$past(ad2_w)))
        else $error("clear alias touched a zero bit");

    // zero bits of a set word keep their value
    AST_SET_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_set
        |=> (stat_q & ~$past(ad2_w)) == ($past(stat_q) & ~$past(ad2_w)))
        else $error("set alias touched a zero bit");

    // an all-zero invert word is a no-op
    AST_INV_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_inv && ad2_w == 2'h0
        |=> $stable(stat_q))
        else $error("empty invert word changed status");

    // reserved bits stay zero and outputs keep tracking the pins
    AST_OUTRO: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_clr || wr_set || wr_inv
        |=> stat_rd_w[12:2] == 11'h000 && stat_rd_w[31:15] == 17'h00000
            && stat_rd_w[1:0] == $past(cmp_out_i))
        else $error("alias write touched read-only bits");

    // clear alias reads as the fixed undefined value
    AST_CLRRD: assert property (@(posedge clk_i) disable iff (rst_i)
        req_w && !wb_req_i.we && wb_req_i.adr == csi_pkg::OFF_STAT_CLR
        |=> wb_rsp_o.ack && wb_rsp_o.dat == 32'h0000_0000)
        else $error("clear alias read not zero");

    // set alias reads as the fixed undefined value
    AST_ALIASRD: assert property (@(posedge clk_i) disable iff (rst_i)
        req_w && !wb_req_i.we && wb_req_i.adr == csi_pkg::OFF_STAT_SET
        |=> wb_rsp_o.ack && wb_rsp_o.dat == 32'h0000_0000)
        else $error("alias read not zero");

    // invert alias reads as the fixed undefined value
    AST_INVRD: assert property (@(posedge clk_i) disable iff (rst_i)
        req_w && !wb_req_i.we && wb_req_i.adr == csi_pkg::OFF_STAT_INV
        |=> wb_rsp_o.ack && wb_rsp_o.dat == 32'h0000_0000)
        else $error("invert alias read not zero");

    // flags come out of reset clear
    AST_FLAG_RST: assert property (@(posedge clk_i)
        rst_i
        |=> flag_q == 2'h0)
        else $error("flags not cleared by reset");

    // a flag write with no event lands as written
    AST_FLAG_WR: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_flag && event_w == 2'h0
        |=> flag_q == $past(fw_w))
        else $error("flag write not taken");

    // flags read back at bits 3 and 4
    AST_FLAG_RD: assert property (@(posedge clk_i) disable iff (rst_i)
        req_w && !wb_req_i.we && wb_req_i.adr == csi_pkg::OFF_IFLAG
        |=> wb_rsp_o.dat == {27'h0, $past(flag_q), 3'h0})
        else $error("flag read wrong");

    // comparator 2 flag sticks until written
    AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        flag_q[1] && !wr_flag
        |=> flag_q[1])
        else $error("flag lost without write");

    // comparator 1 flag sticks until written
    AST_HOLD1: assert property (@(posedge clk_i) disable iff (rst_i)
        flag_q[0] && !wr_flag
        |=> flag_q[0])
        else $error("flag 1 lost without write");

    // comparator 1 event always shows in its flag
    AST_EVT0: assert property (@(posedge clk_i) disable iff (rst_i)
        event_w[0]
        |=> flag_q[0])
        else $error("event 1 not flagged");

    // comparator 2 event always shows in its flag
    AST_EVT1: assert property (@(posedge clk_i) disable iff (rst_i)
        event_w[1]
        |=> flag_q[1])
        else $error("event 2 not flagged");

    // enables come out of reset clear
    AST_EN_RST: assert property (@(posedge clk_i)
        rst_i
        |=> en_q == 2'h0)
        else $error("enables not cleared by reset");

    // an enable write lands as written
    AST_EN_WR: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_en
        |=> en_q == $past({wd_w[csi_pkg::IRQ_CMP2], wd_w[csi_pkg::IRQ_CMP1]}))
        else $error("enable write not taken");

    // enables read back at bits 3 and 4
    AST_EN_RD: assert property (@(posedge clk_i) disable iff (rst_i)
        req_w && !wb_req_i.we && wb_req_i.adr == csi_pkg::OFF_IEN
        |=> wb_rsp_o.dat == {27'h0, $past(en_q), 3'h0})
        else $error("enable read wrong");

    // comparator 1 request forwarded when enabled
    AST_FWD: assert property (@(posedge clk_i) disable iff (rst_i)
        flag_q[0] && en_q[0] && pri1_q != 3'h0
        |-> irq_o)
        else $error("enabled request not forwarded");

    // comparator 2 request forwarded when enabled
    AST_FWD2: assert property (@(posedge clk_i) disable iff (rst_i)
        flag_q[1] && en_q[1] && pri2_q != 3'h0
        |-> irq_o)
        else $error("enabled request 2 not forwarded");

    // nothing enabled, nothing forwarded
    AST_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
        !en_q[0] && !en_q[1]
        |-> !irq_o)
        else $error("irq while disabled");

    // comparator 1 blocked, comparator 2 quiet
    AST_BLOCK1: assert property (@(posedge clk_i) disable iff (rst_i)
        !en_q[0] && !(flag_q[1] && en_q[1])
        |-> !irq_o)
        else $error("blocked request 1 forwarded");

    // comparator 2 blocked, comparator 1 quiet
    AST_BLOCK2: assert property (@(posedge clk_i) disable iff (rst_i)
        !en_q[1] && !(flag_q[0] && en_q[0])
        |-> !irq_o)
        else $error("blocked request 2 forwarded");

    // priority code zero disables both requests
    AST_PRIOFF: assert property (@(posedge clk_i) disable iff (rst_i)
        pri1_q == 3'h0 && pri2_q == 3'h0
        |-> !irq_o)
        else $error("irq with priority zero");

    // priority fields land at 12:10 and 20:18
    AST_PRI_WR: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_pri
        |=> pri1_q == $past(wd_w[12:10]) && pri2_q == $past(wd_w[20:18]))
        else $error("priority write misplaced");

    // subpriority fields land at 9:8 and 17:16
    AST_SUB_WR: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_pri
        |=> sub1_q == $past(wd_w[9:8]) && sub2_q == $past(wd_w[17:16]))
        else $error("subpriority write misplaced");

    // all priority fields come out of reset zero
    AST_PRI_RST: assert property (@(posedge clk_i)
        rst_i
        |=> pri1_q == 3'h0 && sub1_q == 2'h0 && pri2_q == 3'h0 && sub2_q == 2'h0)
        else $error("priority not cleared by reset");

    // polling works with the enable off
    AST_POLL: assert property (@(posedge clk_i) disable iff (rst_i)
        event_w[0] && !en_q[0]
        |=> flag_q[0])
        else $error("flag not set while disabled");

    // comparator 2 any-change raises its flag
    AST_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
        evcfg_q[3:2] == 2'h3 && cmp_out_i[1] != out_q[1]
        |=> flag_q[1])
        else $error("output change raised no request");

    // comparator 1 any-change raises its flag
    AST_EDGE1: assert property (@(posedge clk_i) disable iff (rst_i)
        evcfg_q[1:0] == 2'h3 && cmp_out_i[0] != out_q[0]
        |=> flag_q[0])
        else $error("output 1 change raised no request");
endmodule

// ==== verification/tb_top.sv ====
/*
 * Self-checking bench for the comparator status and interrupt register bank.
 * Assumes the csi_regs slave answers one cycle after a taken request and
 * drives the comparator outputs and the Wishbone request straight from here.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                 clk_i       = 1'h0;
    logic                 rst_i       = 1'h1;
    csi_pkg::csi_wb_req_t req         = '0;
    csi_pkg::csi_wb_rsp_t rsp;
    logic [1:0]           cmp         = 2'h0;
    logic                 irq;
    csi_pkg::csi_prio_t   p1;
    csi_pkg::csi_prio_t   p2;
    logic [31:0]          rd;
    int                   err_total   = 0;
    int                   check_count = 0;
    int                   cyc_n       = 0;

    csi_regs dut (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .wb_req_i    (req),
        .wb_rsp_o    (rsp),
        .cmp_out_i   (cmp),
        .irq_o       (irq),
        .cmp1_prio_o (p1),
        .cmp2_prio_o (p2)
    );

    // 50 ns period
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    // hang guard: the whole sequence needs well under 400 cycles
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 2000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (err_total == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one classic cycle; held until ack is sampled, released at that edge
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                       output logic [31:0] q);
        @(posedge clk_i);
        req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: adr, sel: 4'hF, dat: wd};
        do @(posedge clk_i); while (rsp.ack !== 1'h1);
        q = rsp.dat;
        req <= '0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        bus(1'h1, adr, wd, rd);
    endtask

    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
        bus(1'h0, adr, 32'h0000_0000, rd);
        chk(rd, exp);
    endtask

    // comparator outputs change off the sampling edge, then settle into a flag
    task automatic drive_cmp(input logic [1:0] v);
        @(posedge clk_i);
        cmp <= v;
        repeat (3) @(posedge clk_i);
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        // reset values of the interrupt side
        rdc(csi_pkg::OFF_IFLAG, 32'h0000_0000);
        rdc(csi_pkg::OFF_IEN, 32'h0000_0000);
        rdc(csi_pkg::OFF_IPRIO, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        // alias ports: only the two writable status bits may move
        wr(csi_pkg::OFF_STAT_SET, 32'hFFFF_FFFF);
        rdc(csi_pkg::OFF_STAT, 32'h0000_6000);
        wr(csi_pkg::OFF_STAT_CLR, 32'h0000_2000);
        rdc(csi_pkg::OFF_STAT, 32'h0000_4000);
        wr(csi_pkg::OFF_STAT_INV, 32'h0000_6003);
        rdc(csi_pkg::OFF_STAT, 32'h0000_2000);
        wr(csi_pkg::OFF_STAT_CLR, 32'h0000_0000);
        rdc(csi_pkg::OFF_STAT, 32'h0000_2000);
        wr(csi_pkg::OFF_STAT_INV, 32'h0000_0000);
        rdc(csi_pkg::OFF_STAT, 32'h0000_2000);
        rdc(csi_pkg::OFF_STAT_CLR, csi_pkg::RD_UNDEF);
        rdc(csi_pkg::OFF_STAT_INV, csi_pkg::RD_UNDEF);
        rdc(csi_pkg::OFF_STAT_SET, csi_pkg::RD_UNDEF);
        rdc(8'hFC, 32'h0000_0000);
        // comparator 1 event with its enable still off
        drive_cmp(2'h1);
        rdc(csi_pkg::OFF_IFLAG, 32'h0000_0008);
        chk({31'h0, irq}, 32'h0000_0000);
        rdc(csi_pkg::OFF_STAT, 32'h0000_2001);
        wr(csi_pkg::OFF_IEN, 32'h0000_0008);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(csi_pkg::OFF_IPRIO, 32'h0000_0400);
        chk({31'h0, irq}, 32'h0000_0001);
        chk({27'h0, p1}, 32'h0000_0004);
        wr(csi_pkg::OFF_IEN, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(csi_pkg::OFF_IFLAG, 32'h0000_0000);
        rdc(csi_pkg::OFF_IFLAG, 32'h0000_0000);
        // all priority fields at their widest codes, nothing else sticks
        wr(csi_pkg::OFF_IPRIO, 32'hFFFF_FFFF);
        rdc(csi_pkg::OFF_IPRIO, 32'h001F_1F00);
        chk({22'h0, p2, p1}, 32'h0000_03FF);
        // comparator 2 event, then its enable lets it through
        drive_cmp(2'h3);
        rdc(csi_pkg::OFF_IFLAG, 32'h0000_0010);
        wr(csi_pkg::OFF_IEN, 32'h0000_0010);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(csi_pkg::OFF_IFLAG, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        // comparator 1 on rising edges only: a fall must not raise the flag
        wr(csi_pkg::OFF_EVCFG, 32'h0000_000D);
        drive_cmp(2'h2);
        rdc(csi_pkg::OFF_IFLAG, 32'h0000_0000);
        drive_cmp(2'h3);
        rdc(csi_pkg::OFF_IFLAG, 32'h0000_0008);
        rdc(csi_pkg::OFF_EVCFG, 32'h0000_000D);
        report_and_stop();
    end
endmodule
